//--- design/lbc_pkg.sv
// constants, field layout and line-state encoding of the line-feed, bias and battery control registers
// assumes an apb master with 32-bit data and a 12-bit byte address
package lbc_pkg;

  // ==========================================================================
  // bus
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] LINEFEED_IDX = 8'h40;
  localparam logic [7:0] BIAS_IDX = 8'h41;
  localparam logic [7:0] BATTERY_IDX = 8'h42;
  localparam logic [ADDR_W-1:0] LINEFEED_ADDR = {2'h0, LINEFEED_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] BIAS_ADDR = {2'h0, BIAS_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] BATTERY_ADDR = {2'h0, BATTERY_IDX, 2'h0};

  // ==========================================================================
  // reset values and writable bits
  localparam logic [REG_W-1:0] LINEFEED_RST = 8'h00;
  localparam logic [REG_W-1:0] BIAS_RST = 8'h00;
  localparam logic [REG_W-1:0] BATTERY_RST = 8'h00;
  localparam logic [REG_W-1:0] LINEFEED_WMASK = 8'h07;
  localparam logic [REG_W-1:0] BIAS_WMASK = 8'h7f;
  localparam logic [REG_W-1:0] BATTERY_WMASK = 8'h19;

  // ==========================================================================
  // field positions
  localparam int CMD_LSB = 0;
  localparam int SHADOW_LSB = 4;
  localparam int SQUELCH_BIT = 6;
  localparam int BYPASS_BIT = 5;
  localparam int BIASEN_BIT = 4;
  localparam int ONHOOK_LSB = 2;
  localparam int ACTIVE_LSB = 0;
  localparam int OVERHEAD_BIT = 4;
  localparam int FORCE_BIT = 3;
  localparam int TRACK_BIT = 0;
  localparam int STATE_W = 3;
  localparam int LEVEL_W = 2;

  // ==========================================================================
  // bias current codes
  localparam logic [LEVEL_W-1:0] BIAS_4MA = 2'h0;
  localparam logic [LEVEL_W-1:0] BIAS_8MA = 2'h1;
  localparam logic [LEVEL_W-1:0] BIAS_12MA = 2'h2;
  localparam logic [LEVEL_W-1:0] BIAS_RESERVED = 2'h3;

  localparam int SYNC_STAGES = 2;

  typedef enum logic [STATE_W-1:0] {
    LS_OPEN = 3'h0,
    LS_FWD_ACTIVE = 3'h1,
    LS_FWD_ONHOOK_TX = 3'h2,
    LS_TIP_OPEN = 3'h3,
    LS_RINGING = 3'h4,
    LS_REV_ACTIVE = 3'h5,
    LS_REV_ONHOOK_TX = 3'h6,
    LS_RING_OPEN = 3'h7
  } line_state_type;

endpackage : lbc_pkg

//--- design/lbc_sync.sv
// level synchroniser for one pin input
// assumes the input is asynchronous to mclk
module lbc_sync #(
  parameter int STAGES = lbc_pkg::SYNC_STAGES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic asyncIn,
  output logic syncOut
);
  import lbc_pkg::*;

  logic [STAGES-1:0] chain_q;
  logic [STAGES-1:0] chain_d;

  // ==========================================================================
  // chain
  always_comb begin
    chain_d = {chain_q[STAGES-2:0], asyncIn};
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      chain_q <= '0;
    end else begin
      chain_q <= chain_d;
    end
  end

  // only the last stage leaves the module
  assign syncOut = chain_q[STAGES-1];

endmodule : lbc_sync

//--- design/lbc_line_state.sv
// actual line-state tracker: follows the commanded state except where automatic
// operations (ring cadence, overrides) put the line somewhere else
// assumes ringBurst is already synchronous to mclk
module lbc_line_state (
  input wire logic mclk,
  input wire logic reset,
  input lbc_pkg::line_state_type commanded,
  input wire logic ringBurst,
  input wire logic overrideValid,
  input lbc_pkg::line_state_type overrideState,
  output lbc_pkg::line_state_type actual
);
  import lbc_pkg::*;

  line_state_type actual_q;
  line_state_type actual_d;

  // ==========================================================================
  // next state
  always_comb begin
    actual_d = commanded;
    if (overrideValid) begin
      actual_d = overrideState;
    end else if (commanded == LS_RINGING) begin
      // silent period sits in on-hook transmission
      actual_d = ringBurst ? LS_RINGING : LS_FWD_ONHOOK_TX;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      actual_q <= LS_OPEN;
    end else begin
      actual_q <= actual_d;
    end
  end

  assign actual = actual_q;

endmodule : lbc_line_state

//--- design/lbc_regs.sv
// apb register bank for line-feed state, external transistor bias and battery feed
// assumes an apb master on mclk; ring cadence burst arrives from a pin,
// automatic overrides arrive from logic on mclk
module lbc_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lbc_pkg::ADDR_W-1:0] paddr,
  input wire logic [lbc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [lbc_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic ringBurstPin,
  input wire logic overrideValid,
  input lbc_pkg::line_state_type overrideState,
  output lbc_pkg::line_state_type commandedLineState,
  output lbc_pkg::line_state_type actualLineState,
  output logic audioSquelch,
  output logic capacitorBypass,
  output logic transistorBiasEnable,
  output logic [lbc_pkg::LEVEL_W-1:0] onhookTxBiasLevel,
  output logic [lbc_pkg::LEVEL_W-1:0] activeOffhookBiasLevel,
  output logic [lbc_pkg::LEVEL_W-1:0] appliedBiasLevel,
  output logic biasApplied,
  output logic overheadRangeSelect,
  output logic manualBatteryForce,
  output logic trackingMode
);
  import lbc_pkg::*;

  // ==========================================================================
  // address decode
  function automatic logic [2:0] decodeHit(input logic [ADDR_W-1:0] addr);
    logic [2:0] hit;
    hit = 3'h0;
    if (addr == LINEFEED_ADDR) begin
      hit = 3'h1;
    end else if (addr == BIAS_ADDR) begin
      hit = 3'h2;
    end else if (addr == BATTERY_ADDR) begin
      hit = 3'h4;
    end
    return hit;
  endfunction : decodeHit

  function automatic logic [REG_W-1:0] mergeWrite(input logic [REG_W-1:0] old,
                                                  input logic [REG_W-1:0] wdata,
                                                  input logic [REG_W-1:0] mask);
    return (old & ~mask) | (wdata & mask);
  endfunction : mergeWrite

  logic ringBurstSync;
  line_state_type actualState;

  lbc_sync #(
    .STAGES(SYNC_STAGES)
  ) u_burst_sync (
    .mclk(mclk),
    .reset(reset),
    .asyncIn(ringBurstPin),
    .syncOut(ringBurstSync)
  );

  // ==========================================================================
  // apb slave and registers
  logic [REG_W-1:0] lineReg_q;
  logic [REG_W-1:0] lineReg_d;
  logic [REG_W-1:0] biasReg_q;
  logic [REG_W-1:0] biasReg_d;
  logic [REG_W-1:0] battReg_q;
  logic [REG_W-1:0] battReg_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic [2:0] hit;
  logic setupPhase;
  logic writeDone;
  logic [REG_W-1:0] readValue;
  logic [REG_W-1:0] wrByte;

  lbc_line_state u_line_state (
    .mclk(mclk),
    .reset(reset),
    .commanded(line_state_type'(lineReg_q[CMD_LSB +: STATE_W])),
    .ringBurst(ringBurstSync),
    .overrideValid(overrideValid),
    .overrideState(overrideState),
    .actual(actualState)
  );

  always_comb begin
    hit = decodeHit(paddr);
    setupPhase = psel && !penable;
    writeDone = psel && penable && pready_q && pwrite && pstrb[0] && (hit != 3'h0);
    wrByte = pwdata[REG_W-1:0];
    // shadow bits come from the tracker, never from the stored byte
    readValue = '0;
    if (hit[0]) begin
      readValue = {1'b0, actualState, 1'b0, lineReg_q[CMD_LSB +: STATE_W]};
    end else if (hit[1]) begin
      readValue = biasReg_q;
    end else if (hit[2]) begin
      readValue = battReg_q;
    end
    // one wait-free access phase: answer registered from the setup cycle
    pready_d = setupPhase;
    pslverr_d = setupPhase && (hit == 3'h0);
    prdata_d = prdata_q;
    if (setupPhase) begin
      prdata_d = pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, readValue};
    end
    lineReg_d = lineReg_q;
    biasReg_d = biasReg_q;
    battReg_d = battReg_q;
    if (writeDone && hit[0]) begin
      lineReg_d = mergeWrite(lineReg_q, wrByte, LINEFEED_WMASK);
    end
    if (writeDone && hit[1]) begin
      // reserved level codes are stored as written; the field is not checked
      biasReg_d = mergeWrite(biasReg_q, wrByte, BIAS_WMASK);
    end
    if (writeDone && hit[2]) begin
      battReg_d = mergeWrite(battReg_q, wrByte, BATTERY_WMASK);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      lineReg_q <= LINEFEED_RST;
      biasReg_q <= BIAS_RST;
      battReg_q <= BATTERY_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      lineReg_q <= lineReg_d;
      biasReg_q <= biasReg_d;
      battReg_q <= battReg_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================================
  // bias level applied in the actual line state
  logic [LEVEL_W-1:0] appliedLevel_q;
  logic [LEVEL_W-1:0] appliedLevel_d;
  logic biasApplied_q;
  logic biasApplied_d;

  always_comb begin
    appliedLevel_d = BIAS_4MA;
    biasApplied_d = 1'b0;
    case (actualState)
      LS_FWD_ONHOOK_TX, LS_REV_ONHOOK_TX: begin
        appliedLevel_d = biasReg_q[ONHOOK_LSB +: LEVEL_W];
        biasApplied_d = biasReg_q[BIASEN_BIT];
      end
      LS_FWD_ACTIVE, LS_REV_ACTIVE: begin
        appliedLevel_d = biasReg_q[ACTIVE_LSB +: LEVEL_W];
        biasApplied_d = biasReg_q[BIASEN_BIT];
      end
      default: begin
        appliedLevel_d = BIAS_4MA;
        biasApplied_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      appliedLevel_q <= BIAS_4MA;
      biasApplied_q <= 1'b0;
    end else begin
      appliedLevel_q <= appliedLevel_d;
      biasApplied_q <= biasApplied_d;
    end
  end

  // ==========================================================================
  // outputs, all flop slices
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign commandedLineState = line_state_type'(lineReg_q[CMD_LSB +: STATE_W]);
  assign actualLineState = actualState;
  assign audioSquelch = biasReg_q[SQUELCH_BIT];
  assign capacitorBypass = biasReg_q[BYPASS_BIT];
  assign transistorBiasEnable = biasReg_q[BIASEN_BIT];
  assign onhookTxBiasLevel = biasReg_q[ONHOOK_LSB +: LEVEL_W];
  assign activeOffhookBiasLevel = biasReg_q[ACTIVE_LSB +: LEVEL_W];
  assign appliedBiasLevel = appliedLevel_q;
  assign biasApplied = biasApplied_q;
  assign overheadRangeSelect = battReg_q[OVERHEAD_BIT];
  assign manualBatteryForce = battReg_q[FORCE_BIT];
  assign trackingMode = battReg_q[TRACK_BIT];

  // ==========================================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic lineWr;
  logic biasWr;
  logic battWr;
  assign lineWr = writeDone && hit[0];
  assign biasWr = writeDone && hit[1];
  assign battWr = writeDone && hit[2];

  cmd_write_a: assert property (
    lineWr |=> commandedLineState == line_state_type'($past(pwdata[2:0])))
    else $error("commanded line state did not take the written code");

  shadow_read_a: assert property (
    (setupPhase && !pwrite && hit[0])
    |=> pready && prdata[6:4] == $past(actualLineState) && prdata[7] == 1'b0
        && prdata[3] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("shadow read does not show actual line state");

  shadow_ro_a: assert property (
    (lineWr && !overrideValid && commandedLineState != LS_RINGING
     && pwdata[2:0] != 3'h4)
    |-> ##2 actualLineState == line_state_type'($past(pwdata[2:0], 2)))
    else $error("actual state did not follow a plain commanded state");

  ring_burst_a: assert property (
    (commandedLineState == LS_RINGING && !overrideValid && ringBurstSync)
    |=> actualLineState == LS_RINGING)
    else $error("ring burst not shown as ringing");

  ring_silent_a: assert property (
    (commandedLineState == LS_RINGING && !overrideValid && !ringBurstSync)
    |=> actualLineState == LS_FWD_ONHOOK_TX)
    else $error("silent period not shown as on-hook transmission");

  squelch_bypass_a: assert property (
    biasWr |=> audioSquelch == $past(pwdata[6]) && capacitorBypass == $past(pwdata[5]))
    else $error("squelch or bypass did not take the written value");

  bias_enable_a: assert property (
    (actualLineState == LS_FWD_ACTIVE && !transistorBiasEnable)
    |=> !biasApplied)
    else $error("bias applied while disabled");

  onhook_level_a: assert property (
    (actualLineState == LS_REV_ONHOOK_TX && transistorBiasEnable)
    |=> biasApplied && appliedBiasLevel == $past(onhookTxBiasLevel))
    else $error("on-hook bias level wrong");

  active_level_a: assert property (
    (actualLineState == LS_FWD_ACTIVE && transistorBiasEnable)
    |=> biasApplied && appliedBiasLevel == $past(activeOffhookBiasLevel))
    else $error("active bias level wrong");

  battery_bits_a: assert property (
    battWr |=> overheadRangeSelect == $past(pwdata[4]) && trackingMode == $past(pwdata[0])
               && manualBatteryForce == $past(pwdata[3]))
    else $error("battery feed bits did not take the written value");

  unmapped_err_a: assert property (
    (setupPhase && hit == 3'h0) |=> pready && pslverr)
    else $error("unmapped access not refused");

  strobe_ignore_a: assert property (
    (psel && penable && pready && pwrite && !pstrb[0])
    |=> $stable(lineReg_q) && $stable(biasReg_q) && $stable(battReg_q))
    else $error("write with lane 0 off changed a register");

  unmapped_write_a: assert property (
    (psel && penable && pready && pwrite && hit == 3'h0)
    |=> $stable(lineReg_q) && $stable(biasReg_q) && $stable(battReg_q))
    else $error("unmapped write changed a register");

  bias_read_a: assert property (
    (setupPhase && !pwrite && hit[1])
    |=> prdata[31:7] == 25'h0000000 && prdata[6:0] == $past({audioSquelch, capacitorBypass,
        transistorBiasEnable, onhookTxBiasLevel, activeOffhookBiasLevel}))
    else $error("bias register read does not match its outputs");

  battery_read_a: assert property (
    (setupPhase && !pwrite && hit[2])
    |=> prdata == {27'h0000000, $past(overheadRangeSelect), $past(manualBatteryForce),
                   2'h0, $past(trackingMode)})
    else $error("battery register read does not match its outputs");

  ring_cycle_c: cover property (
    commandedLineState == LS_RINGING && actualLineState == LS_RINGING
    ##[1:20] actualLineState == LS_FWD_ONHOOK_TX);
  shadow_differs_c: cover property (
    pready && !pwrite && prdata[6:4] != prdata[2:0]);
  reserved_level_c: cover property (biasWr && pwdata[3:2] == BIAS_RESERVED);
  back_to_back_c: cover property (pready ##1 pready);
  override_ring_c: cover property (commandedLineState == LS_RINGING && overrideValid);

endmodule : lbc_regs

//--- sim/lbc_regs_tb.sv
// self-checking bench for the line-feed, bias and battery control register bank
// assumes lbc_pkg and lbc_regs are compiled first; the bench is the only apb master
module lbc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lbc_pkg::*;

  // ==========================================================================
  // stimulus and observed signals
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, ringBurstPin = 1'b0, overrideValid = 1'b0;
  logic [DATA_W-1:0] prdata;
  line_state_type overrideState = LS_OPEN;
  line_state_type commandedLineState, actualLineState;
  logic audioSquelch, capacitorBypass, transistorBiasEnable, biasApplied;
  logic [LEVEL_W-1:0] onhookTxBiasLevel, activeOffhookBiasLevel, appliedBiasLevel;
  logic overheadRangeSelect, manualBatteryForce, trackingMode;
  int mismatches = 0;
  int checked = 0;

  always #4 mclk = ~mclk;

  lbc_regs DUT (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ringBurstPin(ringBurstPin), .overrideValid(overrideValid),
    .overrideState(overrideState), .commandedLineState(commandedLineState),
    .actualLineState(actualLineState), .audioSquelch(audioSquelch),
    .capacitorBypass(capacitorBypass), .transistorBiasEnable(transistorBiasEnable),
    .onhookTxBiasLevel(onhookTxBiasLevel), .activeOffhookBiasLevel(activeOffhookBiasLevel),
    .appliedBiasLevel(appliedBiasLevel), .biasApplied(biasApplied),
    .overheadRangeSelect(overheadRangeSelect), .manualBatteryForce(manualBatteryForce),
    .trackingMode(trackingMode)
  );

  // ==========================================================================
  // shared tasks
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // leading edge keeps the previous release and the next setup in different steps
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [3:0] st, output logic [DATA_W-1:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] st);
    logic [DATA_W-1:0] rd;
    logic err;
    apb(1'b1, a, {24'hffffff, d}, st, rd, err);
    chk(32'(err), 32'h0);
  endtask : wr

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input logic eErr);
    logic [DATA_W-1:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, 4'hf, rd, err);
    chk(rd, {24'h0, exp});
    chk(32'(err), 32'(eErr));
  endtask : rdc

  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    chk(32'({commandedLineState, actualLineState, onhookTxBiasLevel, trackingMode}), 32'h0);
    rdc(LINEFEED_ADDR, 8'h00, 1'b0);
    rdc(BIAS_ADDR, 8'h00, 1'b0);
    rdc(BATTERY_ADDR, 8'h00, 1'b0);
  endtask : t_reset

  // every code, with read-only and reserved bits written as ones
  task automatic t_linefeed;
    logic [2:0] c, e;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      e = (c == 3'h4) ? 3'h2 : c;
      wr(LINEFEED_ADDR, {5'h1f, c}, 4'hf);
      settle();
      chk(32'(commandedLineState), 32'(c));
      chk(32'(actualLineState), 32'(e));
      rdc(LINEFEED_ADDR, {1'b0, e, 1'b0, c}, 1'b0);
    end
  endtask : t_linefeed

  task automatic t_ring;
    wr(LINEFEED_ADDR, 8'h04, 4'hf);
    ringBurstPin <= 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    chk(32'(actualLineState), 32'h4);
    rdc(LINEFEED_ADDR, 8'h44, 1'b0);
    ringBurstPin <= 1'b0;
    overrideValid <= 1'b1;
    overrideState <= LS_RING_OPEN;
    settle();
    chk(32'(actualLineState), 32'h7);
    @(posedge mclk);
    overrideValid <= 1'b0;
    settle();
    chk(32'(actualLineState), 32'h2);
    rdc(LINEFEED_ADDR, 8'h24, 1'b0);
  endtask : t_ring

  // reserved level code 11 is never written
  task automatic t_bias;
    logic [7:0] bv [4] = '{8'hc0, 8'ha1, 8'h96, 8'h88};
    for (int i = 0; i < 4; i++) begin
      wr(BIAS_ADDR, bv[i], 4'hf);
      settle();
      chk(32'({audioSquelch, capacitorBypass, transistorBiasEnable}), 32'(bv[i][6:4]));
      chk(32'({onhookTxBiasLevel, activeOffhookBiasLevel}), 32'(bv[i][3:0]));
      rdc(BIAS_ADDR, bv[i] & 8'h7f, 1'b0);
    end
    wr(BIAS_ADDR, 8'h16, 4'hf);
    wr(LINEFEED_ADDR, 8'h01, 4'hf);
    settle();
    chk(32'({biasApplied, appliedBiasLevel}), 32'h6);
    wr(LINEFEED_ADDR, 8'h06, 4'hf);
    settle();
    chk(32'({biasApplied, appliedBiasLevel}), 32'h5);
    wr(BIAS_ADDR, 8'h06, 4'hf);
    settle();
    chk(32'(biasApplied), 32'h0);
  endtask : t_bias

  task automatic t_battery;
    logic [7:0] tv [5] = '{8'hff, 8'h10, 8'h08, 8'h01, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(BATTERY_ADDR, tv[i], 4'hf);
      settle();
      chk(32'({overheadRangeSelect, manualBatteryForce, trackingMode}),
          32'({tv[i][4], tv[i][3], tv[i][0]}));
      rdc(BATTERY_ADDR, tv[i] & 8'h19, 1'b0);
    end
  endtask : t_battery

  // unmapped place answers with an error and leaves the bank alone
  task automatic t_errors;
    logic [DATA_W-1:0] rd;
    logic err;
    wr(BIAS_ADDR, 8'h21, 4'hf);
    apb(1'b1, 12'h10c, 32'h7f, 4'hf, rd, err);
    chk(32'(err), 32'h1);
    rdc(12'h10c, 8'h00, 1'b1);
    apb(1'b1, 12'h0c4, 32'h7f, 4'hf, rd, err);
    chk(32'(err), 32'h1);
    wr(BIAS_ADDR, 8'h5e, 4'he);
    settle();
    chk(32'(capacitorBypass), 32'h1);
    rdc(BIAS_ADDR, 8'h21, 1'b0);
  endtask : t_errors

  // reset in mid-run brings the bank back to zero
  task automatic t_midreset;
    wr(BATTERY_ADDR, 8'h19, 4'hf);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rdc(BATTERY_ADDR, 8'h00, 1'b0);
    rdc(LINEFEED_ADDR, 8'h00, 1'b0);
    rdc(BIAS_ADDR, 8'h00, 1'b0);
  endtask : t_midreset

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_linefeed();
    t_ring();
    t_bias();
    t_battery();
    t_errors();
    t_midreset();
    end_of_test();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

endmodule : lbc_regs_tb
